// ===== logic/pcm_lock_cnt.sv
// Slow-clock down counter that raises a ready flag when it expires
`timescale 1ns/1ps
module pcm_lock_cnt
  import pcm_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rstSync_n,
  input  wire logic                 load,
  input  wire logic                 clearFlag,
  input  wire logic [PCM_CNT_W-1:0] loadVal,
  input  wire logic                 slowRise,
  input  wire logic                 kill,
  output logic                      ready
);
  logic [PCM_CNT_W-1:0] cnt_r;
  logic                 busy_r;

  // Kill beats load so a disabled source never reports ready
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      ready  <= 1'b0;
    end else if (kill) begin
      busy_r <= 1'b0;
      ready  <= 1'b0;
    end else if (load) begin
      cnt_r  <= loadVal;
      busy_r <= 1'b1;
      if (clearFlag) begin
        ready <= 1'b0;
      end
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        ready  <= 1'b1;
        busy_r <= 1'b0;
      end else if (slowRise) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ===== logic/pcm_pkg.sv
// Shared constants and types of the clock manager core
package pcm_pkg;
  // Source codes shared by master and programmable selectors
  typedef enum logic [1:0] {
    PCM_SRC_SLOW = 2'b00,
    PCM_SRC_MAIN = 2'b01,
    PCM_SRC_PLLA = 2'b10,
    PCM_SRC_PLLB = 2'b11
  } pcm_src_t;

  typedef enum logic [1:0] {
    PCM_FM_IDLE  = 2'b00,
    PCM_FM_WAIT  = 2'b01,
    PCM_FM_COUNT = 2'b10,
    PCM_FM_DONE  = 2'b11
  } pcm_fm_t;

  localparam int PCM_NUM_PERIPH  = 32;
  localparam int PCM_NUM_PROG    = 4;
  localparam int PCM_SCALE_MAX   = 6;
  localparam int PCM_CNT_W       = 11;
  localparam int PCM_FREQ_W      = 16;

  // System clock bit positions
  localparam int PCM_SYS_PROC    = 0;
  localparam int PCM_SYS_USB     = 1;
  localparam int PCM_SYS_PROG0   = 8;
  localparam logic [31:0] PCM_SYS_RESET = 32'h0000_0003;

  // Power status bit positions
  localparam int PCM_ST_OSC      = 0;
  localparam int PCM_ST_LOCK_A   = 1;
  localparam int PCM_ST_LOCK_B   = 2;
  localparam int PCM_ST_MRDY     = 3;
  localparam int PCM_ST_PROG0    = 8;

  // Oscillator start-up counts eight slow cycles per unit
  localparam int PCM_OSC_SHIFT   = 3;
  localparam logic [4:0] PCM_FM_SLOW_CYCLES = 5'h10;

  localparam logic [2:0] PCM_SCALE_RESET = 3'h0;
  localparam logic [1:0] PCM_RATIO_RESET = 2'h0;
  localparam logic [7:0] PCM_DIV_RESET   = 8'h00;
  localparam logic [10:0] PCM_MUL_RESET  = 11'h000;
endpackage

// ===== logic/pcm_pow2_div.sv
// Power-of-two clock divider driven by a sampled source level
`timescale 1ns/1ps
module pcm_pow2_div
  import pcm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstSync_n,
  input  wire logic       srcClk,
  input  wire logic [2:0] scale,
  output logic            divClk,
  output logic            divRise
);
  logic       srcPrev_r;
  logic [5:0] cnt_r;
  logic       out_nxt;
  logic       outPrev_r;
  logic [2:0] scaleEff;

  // Codes above the top division clamp to divide by 64
  assign scaleEff = (scale > 3'(PCM_SCALE_MAX)) ? 3'(PCM_SCALE_MAX) : scale;

  // Count source rising edges
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      srcPrev_r <= 1'b0;
      cnt_r     <= 6'h00;
    end else begin
      srcPrev_r <= srcClk;
      if (srcClk && !srcPrev_r) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  // Bit k-1 of the edge count has a period of 2^k source cycles
  always_comb begin
    out_nxt = srcClk;
    if (scaleEff != 3'h0) begin
      out_nxt = cnt_r[scaleEff - 3'h1];
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      divClk    <= 1'b0;
      outPrev_r <= 1'b0;
    end else begin
      divClk    <= out_nxt;
      outPrev_r <= divClk;
    end
  end

  assign divRise = divClk && !outPrev_r;
endmodule

// ===== logic/power_clock_manager_core.sv
// Clock gating, selection, division and ready tracking of the clock manager
`timescale 1ns/1ps
module power_clock_manager_core
  import pcm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        slowClk,
  input  wire logic        mainClk,
  input  wire logic        pllAClk,
  input  wire logic        pllBClk,
  input  wire logic        periphSetWr,
  input  wire logic [31:0] periphSetData,
  input  wire logic        periphClrWr,
  input  wire logic [31:0] periphClrData,
  output logic      [31:0] periphClkState,
  output logic      [31:0] periphClk,
  input  wire logic        sysSetWr,
  input  wire logic [31:0] sysSetData,
  input  wire logic        sysClrWr,
  input  wire logic [31:0] sysClrData,
  output logic      [31:0] sysClkState,
  input  wire logic [3:0]  progCfgWr,
  input  wire logic [1:0]  progSrcData,
  input  wire logic [2:0]  progScaleData,
  output logic      [3:0]  progClkOut,
  input  wire logic        oscCfgWr,
  input  wire logic        oscEnable,
  input  wire logic [7:0]  oscStartupCount,
  output logic             oscStable,
  output logic             freqMeasDone,
  output logic      [15:0] freqMeasValue,
  input  wire logic        pllACfgWr,
  input  wire logic        sourceA,
  input  wire logic [7:0]  predivA,
  input  wire logic [10:0] multiplierA,
  input  wire logic [1:0]  freqRangeA,
  input  wire logic [5:0]  lockCountA,
  input  wire logic        pllBCfgWr,
  input  wire logic [7:0]  predivB,
  input  wire logic [10:0] multiplierB,
  input  wire logic [1:0]  usbRatio,
  input  wire logic [5:0]  lockCountB,
  output logic             lockedA,
  output logic             lockedB,
  output logic             pllAOn,
  output logic             pllBOn,
  output logic      [1:0]  pllARange,
  output logic             pllAIn,
  output logic             pllBIn,
  output logic             usbClk,
  input  wire logic        mstCfgWr,
  input  wire logic [1:0]  mstSrcData,
  input  wire logic [2:0]  mstScaleData,
  input  wire logic [1:0]  procRatioData,
  output logic             masterReady,
  output logic             masterClk,
  output logic             procClk,
  output logic      [31:0] powerStatus,
  input  wire logic [31:0] irqEnable,
  output logic             irq
);
  logic              rstMeta_r;
  logic              rstSync_n;
  logic              slowPrev_r;
  logic              mainPrev_r;
  logic              slowRise;
  logic              mainRise;
  pcm_src_t          progSrc_r  [PCM_NUM_PROG];
  logic [2:0]        progScale_r [PCM_NUM_PROG];
  logic [3:0]        progDiv;
  logic [3:0]        progRise;
  logic [3:0]        progReady_r;
  logic              srcLevel   [PCM_NUM_PROG];
  logic [7:0]        predivA_r;
  logic [7:0]        predivB_r;
  logic [10:0]       multiplier_a_r;
  logic [10:0]       multiplier_b_r;
  logic              source_a_r;
  logic [1:0]        usbRatio_r;
  logic              chgA;
  logic              chgB;
  pcm_src_t          mstSrc_r;
  pcm_src_t          mstSrcEff;
  logic [2:0]        mstScale_r;
  logic [1:0]        procRatio_r;
  logic              mstPend_r;
  logic              mstChg;
  logic              mstSrcLevel;
  logic              procDiv;
  logic              procRise;
  logic              mstDiv;
  logic              pllAGated;
  logic              pllBGated;
  pcm_fm_t           fmState_r;
  logic [4:0]        fmSlowCnt_r;

  // Reset release through two flops; only the second is used
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // Edge detection of sampled slow and main clocks
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      slowPrev_r <= 1'b0;
      mainPrev_r <= 1'b0;
    end else begin
      slowPrev_r <= slowClk;
      mainPrev_r <= mainClk;
    end
  end
  assign slowRise = slowClk && !slowPrev_r;
  assign mainRise = mainClk && !mainPrev_r;

  // Peripheral enables; clear wins when both arrive together
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      periphClkState <= 32'h0000_0000;
    end else begin
      periphClkState <= (periphClkState | (periphSetWr ? periphSetData : 32'h0000_0000))
                        & ~(periphClrWr ? periphClrData : 32'h0000_0000);
    end
  end
  // Bit n gates peripheral n, combinational so a stop is immediate
  assign periphClk = periphClkState & {PCM_NUM_PERIPH{masterClk}};

  // System clock enables for processor, USB and programmable outputs
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sysClkState <= PCM_SYS_RESET;
    end else begin
      sysClkState <= (sysClkState | (sysSetWr ? sysSetData : 32'h0000_0000))
                     & ~(sysClrWr ? sysClrData : 32'h0000_0000);
    end
  end

  // PLL parameters; a change of tracked fields drops the lock
  assign chgA = (sourceA != source_a_r) || (multiplierA != multiplier_a_r) || (predivA != predivA_r);
  assign chgB = (multiplierB != multiplier_b_r) || (predivB != predivB_r);
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      source_a_r     <= 1'b0;
      predivA_r  <= PCM_DIV_RESET;
      predivB_r  <= PCM_DIV_RESET;
      multiplier_a_r     <= PCM_MUL_RESET;
      multiplier_b_r     <= PCM_MUL_RESET;
      pllARange  <= 2'h0;
      usbRatio_r <= PCM_RATIO_RESET;
    end else begin
      if (pllACfgWr) begin
        source_a_r    <= sourceA;
        predivA_r <= predivA;
        multiplier_a_r    <= multiplierA;
        pllARange <= freqRangeA;
      end
      if (pllBCfgWr) begin
        predivB_r  <= predivB;
        multiplier_b_r     <= multiplierB;
        usbRatio_r <= usbRatio;
      end
    end
  end
  assign pllAOn = (multiplier_a_r != PCM_MUL_RESET);
  assign pllBOn = (multiplier_b_r != PCM_MUL_RESET);

  // Pre-divider zero holds the reference low; the analog loop does the rest
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pllAIn <= 1'b0;
      pllBIn <= 1'b0;
    end else begin
      pllAIn <= (predivA_r != PCM_DIV_RESET) && (source_a_r ? mainClk : 1'b0);
      pllBIn <= (predivB_r != PCM_DIV_RESET) && mainClk;
    end
  end
  assign pllAGated = pllAClk && pllAOn && (predivA_r != PCM_DIV_RESET);
  assign pllBGated = pllBClk && pllBOn && (predivB_r != PCM_DIV_RESET);

  // Lock counters reload on every write, clear only on a change
  pcm_lock_cnt u_lock_a (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .load      (pllACfgWr),
    .clearFlag (chgA),
    .loadVal   ({5'h00, lockCountA}),
    .slowRise  (slowRise),
    .kill      (!pllAOn && !pllACfgWr),
    .ready     (lockedA)
  );
  pcm_lock_cnt u_lock_b (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .load      (pllBCfgWr),
    .clearFlag (chgB),
    .loadVal   ({5'h00, lockCountB}),
    .slowRise  (slowRise),
    .kill      (!pllBOn && !pllBCfgWr),
    .ready     (lockedB)
  );

  // Oscillator start-up: eight slow cycles per unit of the count
  pcm_lock_cnt u_osc (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .load      (oscCfgWr && oscEnable),
    .clearFlag (1'b1),
    .loadVal   ({oscStartupCount, 3'h0}),
    .slowRise  (slowRise),
    .kill      (oscCfgWr && !oscEnable),
    .ready     (oscStable)
  );

  // Frequency meter starts on the slow edge after oscillator is stable
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      fmState_r     <= PCM_FM_IDLE;
      fmSlowCnt_r   <= 5'h00;
      freqMeasValue <= 16'h0000;
    end else begin
      case (fmState_r)
        PCM_FM_IDLE: begin
          if (oscStable) begin
            fmState_r <= PCM_FM_WAIT;
          end
        end
        PCM_FM_WAIT: begin
          if (slowRise) begin
            fmState_r     <= PCM_FM_COUNT;
            fmSlowCnt_r   <= 5'h00;
            freqMeasValue <= 16'h0000;
          end
        end
        PCM_FM_COUNT: begin
          if (mainRise) begin
            freqMeasValue <= freqMeasValue + 16'h0001;
          end
          if (slowRise) begin
            fmSlowCnt_r <= fmSlowCnt_r + 5'h01;
            if (fmSlowCnt_r == PCM_FM_SLOW_CYCLES - 5'h01) begin
              fmState_r <= PCM_FM_DONE;
            end
          end
        end
        PCM_FM_DONE: begin
          if (!oscStable) begin
            fmState_r <= PCM_FM_IDLE;
          end
        end
        default: fmState_r <= PCM_FM_IDLE;
      endcase
    end
  end
  assign freqMeasDone = (fmState_r == PCM_FM_DONE);

  // Programmable outputs; no glitch guard, so software disables first
  genvar gi;
  generate
    for (gi = 0; gi < PCM_NUM_PROG; gi++) begin : g_prog
      always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
          progSrc_r[gi]   <= PCM_SRC_SLOW;
          progScale_r[gi] <= PCM_SCALE_RESET;
          progReady_r[gi] <= 1'b0;
          progClkOut[gi]  <= 1'b0;
        end else begin
          if (progCfgWr[gi]) begin
            progSrc_r[gi]  <= pcm_src_t'(progSrcData);
            progScale_r[gi] <= progScaleData;
          end
          // Ready once a divided edge of the new setting came out
          if (progCfgWr[gi] || !sysClkState[PCM_SYS_PROG0 + gi]) begin
            progReady_r[gi] <= 1'b0;
          end else if (progRise[gi]) begin
            progReady_r[gi] <= 1'b1;
          end
          progClkOut[gi] <= progDiv[gi] && sysClkState[PCM_SYS_PROG0 + gi];
        end
      end
      always_comb begin
        case (progSrc_r[gi])
          PCM_SRC_SLOW: srcLevel[gi] = slowClk;
          PCM_SRC_MAIN: srcLevel[gi] = mainClk;
          PCM_SRC_PLLA: srcLevel[gi] = pllAGated;
          PCM_SRC_PLLB: srcLevel[gi] = pllBGated;
          default:      srcLevel[gi] = slowClk;
        endcase
      end
      pcm_pow2_div u_div (
        .clk_sys   (clk_sys),
        .rstSync_n (rstSync_n),
        .srcClk    (srcLevel[gi]),
        .scale     (progScale_r[gi]),
        .divClk    (progDiv[gi]),
        .divRise   (progRise[gi])
      );
    end
  endgenerate

  // USB clock from PLL B, ratio code 0/1/2 divides by 1/2/4
  pcm_pow2_div u_usb_div (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .srcClk    (pllBGated && sysClkState[PCM_SYS_USB]),
    .scale     ({1'b0, usbRatio_r}),
    .divClk    (usbClk),
    .divRise   ()
  );

  // Master configuration; a change of source or prescale drops ready
  assign mstChg = mstCfgWr && ((mstSrcData != mstSrc_r) || (mstScaleData != mstScale_r));
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      mstSrc_r    <= PCM_SRC_SLOW;
      mstScale_r  <= PCM_SCALE_RESET;
      procRatio_r <= PCM_RATIO_RESET;
      mstPend_r   <= 1'b1;
    end else begin
      if (mstCfgWr) begin
        mstSrc_r    <= pcm_src_t'(mstSrcData);
        mstScale_r  <= mstScaleData;
        procRatio_r <= procRatioData;
      end
      if (mstChg) begin
        mstPend_r <= 1'b1;
      end else if (mstSrcEff == mstSrc_r && procRise) begin
        mstPend_r <= 1'b0;
      end
    end
  end

  // Selected PLL unlocked: A falls back to slow, B to main
  always_comb begin
    mstSrcEff = mstSrc_r;
    if (mstSrc_r == PCM_SRC_PLLA && !lockedA) begin
      mstSrcEff = PCM_SRC_SLOW;
    end else if (mstSrc_r == PCM_SRC_PLLB && !lockedB) begin
      mstSrcEff = PCM_SRC_MAIN;
    end
  end
  always_comb begin
    case (mstSrcEff)
      PCM_SRC_SLOW: mstSrcLevel = slowClk;
      PCM_SRC_MAIN: mstSrcLevel = mainClk;
      PCM_SRC_PLLA: mstSrcLevel = pllAGated;
      PCM_SRC_PLLB: mstSrcLevel = pllBGated;
      default:      mstSrcLevel = slowClk;
    endcase
  end
  assign masterReady = !mstPend_r && (mstSrcEff == mstSrc_r);

  pcm_pow2_div u_proc_div (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .srcClk    (mstSrcLevel),
    .scale     (mstScale_r),
    .divClk    (procDiv),
    .divRise   (procRise)
  );
  pcm_pow2_div u_mst_div (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .srcClk    (procDiv),
    .scale     ({1'b0, procRatio_r}),
    .divClk    (mstDiv),
    .divRise   ()
  );
  assign masterClk = mstDiv;
  assign procClk   = procDiv && sysClkState[PCM_SYS_PROC];

  // Status word and interrupt; flags are levels, so nothing is lost
  always_comb begin
    powerStatus = 32'h0000_0000;
    powerStatus[PCM_ST_OSC]   = oscStable;
    powerStatus[PCM_ST_LOCK_A] = lockedA;
    powerStatus[PCM_ST_LOCK_B] = lockedB;
    powerStatus[PCM_ST_MRDY]  = masterReady;
    powerStatus[PCM_ST_PROG0 +: PCM_NUM_PROG] = progReady_r;
  end
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(powerStatus & irqEnable);
    end
  end

  chk_periph_clr_stops: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    periphClrWr && periphClrData[4] |=> !periphClkState[4] && !periphClk[4])
    else $error("peripheral clock 4 still on after clear");
  chk_periph_set_on: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    periphSetWr && periphSetData[8] && !(periphClrWr && periphClrData[8]) |=> periphClkState[8])
    else $error("peripheral clock 8 not enabled by set");
  chk_zero_write_keeps: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    !(sysSetWr && sysSetData[PCM_SYS_PROG0]) && !(sysClrWr && sysClrData[PCM_SYS_PROG0])
    |=> sysClkState[PCM_SYS_PROG0] == $past(sysClkState[PCM_SYS_PROG0]))
    else $error("system clock bit changed without a one written");
  chk_lock_a_drop: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    pllACfgWr && chgA |=> !lockedA)
    else $error("lock A not cleared on parameter change");
  chk_master_ready_drop: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    mstChg |=> !masterReady)
    else $error("master ready not cleared on change");
  chk_fallback_slow: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    mstSrc_r == PCM_SRC_PLLA && !lockedA |-> mstSrcEff == PCM_SRC_SLOW && !masterReady)
    else $error("master not on slow clock while PLL A unlocked");
  chk_prediv_zero: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    predivB_r == PCM_DIV_RESET |-> !pllBGated ##1 !pllBIn)
    else $error("PLL B path active with pre-divider zero");
  chk_irq_gate: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    oscStable && irqEnable[PCM_ST_OSC] |=> irq)
    else $error("interrupt missing for enabled oscillator flag");
  chk_freq_done: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    $rose(freqMeasDone) |-> $past(slowRise) && fmSlowCnt_r == PCM_FM_SLOW_CYCLES)
    else $error("frequency meter stopped at wrong slow cycle");
  chk_prog_ready_drop: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    progCfgWr[0] |=> !progReady_r[0])
    else $error("output ready survived a configuration write");
  chk_pll_off_unlocked: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    !pllBOn && !pllBCfgWr |=> !lockedB)
    else $error("PLL B locked while turned off");
endmodule

// ===== verification/power_clock_manager_core_tb.sv
// Self-checking bench of the clock manager core
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("Error at %0t: %0h not %0h", $time, a, b); end end
module power_clock_manager_core_tb;
  import pcm_pkg::*;
  logic clk_sys, rst_n, slowClk, mainClk, pllAClk, pllBClk, periphSetWr, periphClrWr, sysSetWr, sysClrWr;
  logic oscCfgWr, oscEnable, pllACfgWr, sourceA, pllBCfgWr, mstCfgWr;
  logic [31:0] periphSetData, periphClrData, sysSetData, sysClrData, irqEnable;
  logic [31:0] periphClkState, periphClk, sysClkState, powerStatus;
  logic [3:0]  progCfgWr, progClkOut;
  logic [3:0]  cyc = 4'h0;
  logic [1:0]  progSrcData, freqRangeA, usbRatio, mstSrcData, procRatioData, pllARange;
  logic [2:0]  progScaleData, mstScaleData;
  logic [7:0]  oscStartupCount, predivA, predivB;
  logic [10:0] multiplierA, multiplierB;
  logic [5:0]  lockCountA, lockCountB;
  logic [15:0] freqMeasValue, mon;
  logic        oscStable, freqMeasDone, lockedA, lockedB, pllAOn, pllBOn, pllAIn, pllBIn, usbClk;
  logic        masterReady, masterClk, procClk, irq;
  int          errors, n_tests, nSlow, s, p;

  power_clock_manager_core i_dut (.*);

  // Observed bits: 0-3 outputs, 4 usb, 5 master, 6-9 status, 10-13 output ready, 14 meter, 15 proc
  assign mon = {procClk, freqMeasDone, powerStatus[11:8], powerStatus[3:0], masterClk, usbClk, progClkOut};

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Source clocks from one counter so every period is an exact cycle count
  always @(negedge clk_sys) begin
    if (cyc == 4'h8) nSlow++;
    cyc <= cyc + 4'h1;
    slowClk <= cyc[3];
    mainClk <= cyc[1];
    pllAClk <= cyc[0];
    pllBClk <= cyc[1];
  end

  // Polls just after the edge so the design's updates have landed
  task automatic waitHi(input int i);
    int k;
    for (k = 0; k < 3000 && mon[i] !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (k == 3000) begin
      errors++;
      $display("Error at %0t: wait on bit %0d timed out", $time, i);
    end
  endtask

  // Cycles between two rising edges of an observed clock
  task automatic per(input int i, output int n);
    logic q;
    int   r;
    q = 1'b1;
    r = 0;
    n = 0;
    while (r < 2 && n < 3000) begin
      @(posedge clk_sys);
      #1;
      if (mon[i] === 1'b1 && !q) r++;
      if (r == 1) n++;
      q = mon[i];
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run is under two thousand cycles; this bounds a hang
  initial begin
    #200us;
    errors++;
    give_verdict();
  end

  initial begin
    {rst_n, periphSetWr, periphClrWr, sysSetWr, sysClrWr, oscCfgWr, oscEnable, pllACfgWr, sourceA} = '0;
    {pllBCfgWr, mstCfgWr, periphSetData, periphClrData, sysSetData, sysClrData, irqEnable} = '0;
    {progCfgWr, progSrcData, freqRangeA, usbRatio, mstSrcData, procRatioData, progScaleData} = '0;
    {mstScaleData, oscStartupCount, predivA, predivB, multiplierA, multiplierB, lockCountA, lockCountB} = '0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    `CHK(periphClkState, 32'h0000_0000)
    `CHK(sysClkState, PCM_SYS_RESET)
    `CHK({pllAOn, pllBIn}, 2'h0)
    waitHi(9);
    $display("Reset test done");
    // Peripheral gates, then a zero set word beside a clear
    @(negedge clk_sys) {periphSetWr, periphSetData} = {1'b1, 32'h0000_0110};
    @(negedge clk_sys) {periphSetData, periphClrWr, periphClrData} = {32'h0, 1'b1, 32'h0000_0010};
    `CHK(periphClkState, 32'h0000_0110)
    @(negedge clk_sys) {periphSetWr, periphClrWr} = '0;
    `CHK(periphClkState, 32'h0000_0100)
    `CHK(periphClk[4], 1'b0)
    `CHK(periphClk[8], masterClk)
    $display("Peripheral test done");
    // Oscillator start-up, interrupt, frequency meter
    @(negedge clk_sys) {oscCfgWr, oscEnable, oscStartupCount} = {2'h3, 8'h01};
    @(posedge clk_sys) s = nSlow;
    @(negedge clk_sys) oscCfgWr = 1'b0;
    waitHi(6);
    `CHK(nSlow - s, 8)
    @(negedge clk_sys) irqEnable = 32'h0000_0001;
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'b1)
    irqEnable = 32'h0;
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'b0)
    waitHi(14);
    `CHK(freqMeasValue, 16'h0040)
    $display("Oscillator test done");
    // PLL A lock count, then a changed multiplier drops the lock
    @(negedge clk_sys) {pllACfgWr, sourceA, predivA, multiplierA, lockCountA} = {2'h3, 8'h05, 11'h003, 6'h06};
    @(posedge clk_sys) s = nSlow;
    @(negedge clk_sys) pllACfgWr = 1'b0;
    `CHK({lockedA, pllAOn}, 2'h1)
    waitHi(7);
    `CHK(nSlow - s, 6)
    @(negedge clk_sys) {pllACfgWr, multiplierA} = {1'b1, 11'h007};
    @(negedge clk_sys) pllACfgWr = 1'b0;
    `CHK(lockedA, 1'b0)
    waitHi(7);
    $display("PLL A test done");
    // Master to main: source first, then prescale by 4; master is half the processor
    @(negedge clk_sys) {mstCfgWr, mstSrcData, mstScaleData, procRatioData} = {1'b1, PCM_SRC_MAIN, 3'h0, 2'h1};
    @(negedge clk_sys) mstCfgWr = 1'b0;
    `CHK(masterReady, 1'b0)
    waitHi(9);
    @(negedge clk_sys) {mstCfgWr, mstScaleData} = {1'b1, 3'h2};
    @(negedge clk_sys) mstCfgWr = 1'b0;
    `CHK(masterReady, 1'b0)
    waitHi(9);
    per(5, p);
    `CHK(p, 32)
    per(15, p);
    `CHK(p, 16)
    $display("Master test done");
    // USB clock is PLL B divided by 4, measured after PLL B reports lock
    @(negedge clk_sys) {pllBCfgWr, predivB, multiplierB, usbRatio, lockCountB} = {1'b1, 8'h01, 11'h004, 2'h2, 6'h02};
    @(negedge clk_sys) pllBCfgWr = 1'b0;
    waitHi(8);
    per(4, p);
    `CHK(p, 16)
    $display("USB test done");
    // Each output: source i, divide 2^i, configured while disabled
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys) {progCfgWr, progSrcData, progScaleData} = {4'h1 << i, 2'(i), 3'(i)};
      @(negedge clk_sys) {progCfgWr, sysSetWr, sysSetData} = {4'h0, 1'b1, 32'h100 << i};
      @(negedge clk_sys) sysSetWr = 1'b0;
      `CHK(sysClkState[8 + i], 1'b1)
      waitHi(10 + i);
      per(i, p);
      `CHK(p, (i == 0 ? 16 : i == 2 ? 2 : 4) << i)
      @(negedge clk_sys) {sysClrWr, sysClrData} = {1'b1, 32'h100 << i};
      @(negedge clk_sys) sysClrWr = 1'b0;
      `CHK(sysClkState[8 + i], 1'b0)
    end
    $display("Output test done");
    // Master on PLL A; a PLL A rewrite falls back to slow clock until relock
    @(negedge clk_sys) {mstCfgWr, mstSrcData} = {1'b1, PCM_SRC_PLLA};
    @(negedge clk_sys) mstCfgWr = 1'b0;
    waitHi(9);
    per(5, p);
    `CHK(p, 16)
    @(negedge clk_sys) {pllACfgWr, multiplierA} = {1'b1, 11'h003};
    @(negedge clk_sys) pllACfgWr = 1'b0;
    `CHK(masterReady, 1'b0)
    waitHi(7);
    `CHK(masterReady, 1'b1)
    $display("Fallback test done");
    give_verdict();
  end
endmodule
